// ===== core/wfp_unit.sv
`timescale 1ns/100ps
// How it works
// [R1] A word is eight seven-bit characters, character zero lowest.
// [R2] Character bits 1-4 are numeric, 5-6 zone, 7 the check bit.
// [R3] Each character holds an odd count of ones over all seven bits.
// [R4] Odd parity is checked on every transfer from any source.
// [R5] A parity error raises the interrupt unless errors are ignored; the code also needs its mask bit set.
// [R6] A flag bit of one means set or true, zero means reset or false.
// [R7] Float operations accept only full eight-character fields.
// [R8] Fixed field sign is zone bit six of its lowest character.
// [R9] Other zone bits of a fixed field are normally zero.
// [R10] Float mode is selectable for full-word operations.
// [R11] Character four bit six is fraction sign, bit five exponent sign.
// [R12] Exponent is two BCD digits in zone bits of characters 3 to 0.
// [R13] Exponent magnitude is at most ninety-nine.
// [R14] A zero fraction or exponent must not carry a minus sign.
// [R15] Normalized means the top fraction digit is nonzero.
// [R16] Fraction digits sit in numeric bits, top digit in character 7.
// [R17] Core memory transfers move whole words, parity checked.
module wfp_unit (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic xfer_valid,
   input wire wfp_pkg::wfp_xfer_t xfer_in,
   output logic xfer_err,
   input wire logic gen_valid,
   input wire wfp_pkg::wfp_word_t gen_code,
   output wfp_pkg::wfp_word_t gen_word,
   output logic gen_done,
   output logic irq
);
   logic [31:0] ctrl_q;
   logic [wfp_pkg::EVT_NUM-1:0] sts_q;
   logic [wfp_pkg::EVT_NUM-1:0] mask_q;
   logic [wfp_pkg::NUM_CHARS-1:0] err_chars_q;
   wfp_pkg::wfp_src_t err_src_q;
   wfp_pkg::wfp_word_t word_q;
   wfp_pkg::wfp_word_t gen_word_q;
   logic gen_done_q;
   logic xfer_err_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;

   // control decode
   wire ign_err = ctrl_q[wfp_pkg::CTRL_IGNORE];
   wire float_op = ctrl_q[wfp_pkg::CTRL_FLOAT];
   wire [2:0] field_pos = ctrl_q[wfp_pkg::CTRL_POS_LSB +: 3];
   wire [3:0] field_len = ctrl_q[wfp_pkg::CTRL_LEN_LSB +: 4];
   wire [4:0] field_end = {2'b00, field_pos} + {1'b0, field_len};
   wire field_ok = field_len != 4'h0 && field_end <= 5'(wfp_pkg::FULL_LEN);
   wire field_full = field_len == wfp_pkg::FULL_LEN && field_pos == 3'h0;

   // parity check on incoming words, generation on outgoing codes
   logic [wfp_pkg::NUM_CHARS-1:0] bad_chars;
   wfp_pkg::wfp_word_t gen_fixed;
   wfp_char_parity u_par (
      .chk_word(xfer_in.word),
      .gen_code(gen_code),
      .bad(bad_chars),
      .gen_word(gen_fixed)
   );

   // float decode of the incoming word and of the captured word
   wfp_pkg::wfp_float_t flt_in;
   wfp_pkg::wfp_float_t flt_q;
   wfp_float_decode u_flt_in (
      .word(xfer_in.word),
      .flt(flt_in)
   );
   wfp_float_decode u_flt_q (
      .word(word_q),
      .flt(flt_q)
   );

   // events of a transfer
   wire par_evt = xfer_valid && |bad_chars && !ign_err; // see [R4] [R5]
   wire part_evt = xfer_valid && float_op && !field_full; // see [R7] [R10]
   wire fmt_evt = xfer_valid && float_op &&
                  (flt_in.neg_zero || flt_in.bad_digit); // see [R13] [R14]
   wire [wfp_pkg::EVT_NUM-1:0] evt = {fmt_evt, part_evt, par_evt};

   // fixed field sign and zone checks on the captured word
   wire [55:0] word_bits = word_q;
   wire [55:0] shifted =
      word_bits >> ({3'b000, field_pos} * 6'(wfp_pkg::CHAR_BITS));
   wire wfp_pkg::wfp_word_t field_word = shifted;
   wire field_sign = field_word[0].zone[1]; // see [R8]
   logic [wfp_pkg::NUM_CHARS-1:0] zone_odd;
   genvar i;
   generate
      for (i = 0; i < wfp_pkg::NUM_CHARS; i++) begin : g_zone
         // see [R9]
         assign zone_odd[i] = 4'(i) < field_len &&
            (i == 0 ? field_word[i].zone[0] : |field_word[i].zone);
      end
   endgenerate
   wire zone_nonstd = |zone_odd;

   // bus write decode
   wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
   wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                        {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   wire [31:0] wbits = s_axi_wdata & wmask;
   wire wr_ctrl = wr_go && s_axi_awaddr == wfp_pkg::OFS_CTRL;
   wire wr_sts = wr_go && s_axi_awaddr == wfp_pkg::OFS_STATUS;
   wire wr_mask = wr_go && s_axi_awaddr == wfp_pkg::OFS_MASK;
   wire wr_hit = wr_ctrl || wr_sts || wr_mask;
   wire [wfp_pkg::EVT_NUM-1:0] sts_clr =
      wr_sts ? wbits[wfp_pkg::EVT_NUM-1:0] : '0;
   wire [31:0] ctrl_d = wr_ctrl ?
      (ctrl_q & ~(wmask & wfp_pkg::CTRL_WMASK)) |
      (wbits & wfp_pkg::CTRL_WMASK) : ctrl_q;
   wire [wfp_pkg::EVT_NUM-1:0] mask_d =
      wr_mask ? (mask_q & ~wmask[wfp_pkg::EVT_NUM-1:0]) |
      wbits[wfp_pkg::EVT_NUM-1:0] : mask_q;
   // set wins over a write-one clear in the same cycle
   wire [wfp_pkg::EVT_NUM-1:0] sts_d = (sts_q & ~sts_clr) | evt;

   // bus read decode
   wire rd_go = s_axi_arvalid && !rvalid_q;
   wire [31:0] decode_word = {15'h0, field_ok, flt_q.bad_digit,
      flt_q.neg_zero, flt_q.is_zero, flt_q.normalized, flt_q.exp_units,
      flt_q.exp_tens, flt_q.exp_sign, flt_q.frac_sign, zone_nonstd,
      field_sign}; // see [R11] [R12] [R15] [R16]
   logic [31:0] rd_mux;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         wfp_pkg::OFS_CTRL: rd_mux = ctrl_q;
         wfp_pkg::OFS_STATUS: rd_mux = {29'h0, sts_q};
         wfp_pkg::OFS_MASK: rd_mux = {29'h0, mask_q};
         wfp_pkg::OFS_ERRINFO: rd_mux = {21'h0, err_src_q, err_chars_q};
         wfp_pkg::OFS_WORD_LO: rd_mux = word_bits[31:0];
         wfp_pkg::OFS_WORD_HI: rd_mux = {8'h0, word_bits[55:32]};
         wfp_pkg::OFS_DECODE: rd_mux = decode_word;
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= wfp_pkg::CTRL_RESET;
         mask_q <= '0;
         sts_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
         sts_q <= sts_d; // see [R5] [R6]
      end
   end

   // capture every transfer as a whole word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word_q <= '0;
         xfer_err_q <= 1'b0;
         err_chars_q <= '0;
         err_src_q <= wfp_pkg::SRC_CORE;
      end else begin
         xfer_err_q <= xfer_valid && |bad_chars; // see [R4]
         if (xfer_valid) begin
            word_q <= xfer_in.word; // see [R1] [R17]
         end
         if (xfer_valid && |bad_chars) begin
            err_chars_q <= bad_chars;
            err_src_q <= xfer_in.src;
         end
      end
   end

   // check-bit generation on outgoing codes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gen_word_q <= '0;
         gen_done_q <= 1'b0;
      end else begin
         gen_done_q <= gen_valid;
         if (gen_valid) begin
            gen_word_q <= gen_fixed; // see [R2] [R3]
         end
      end
   end

   // bus answers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= wfp_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= wfp_pkg::RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else begin
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? wfp_pkg::RESP_OKAY : wfp_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? wfp_pkg::RESP_OKAY : wfp_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = rd_go;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign xfer_err = xfer_err_q;
   assign gen_word = gen_word_q;
   assign gen_done = gen_done_q;
   assign irq = |(sts_q & mask_q); // see [R5]

   // checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_WORD_ORDER: assert property ( // see [R1]
      xfer_valid |=> word_bits[6:0] == $past(xfer_in.word[0]) &&
                     word_bits[55:49] == $past(xfer_in.word[7]))
      else $error("captured word characters out of order");
   AST_ODD_GEN: assert property ( // see [R3]
      gen_done |-> ^gen_word[0] && ^gen_word[3] && ^gen_word[7])
      else $error("generated character has even parity");
   AST_PAR_EVT: assert property ( // see [R4]
      xfer_valid && |bad_chars && !ign_err |=> sts_q[wfp_pkg::EVT_PARITY]
      ##0 xfer_err)
      else $error("parity error not recorded");
   AST_PAR_IRQ: assert property ( // see [R5]
      xfer_valid && |bad_chars && !ign_err && mask_q[wfp_pkg::EVT_PARITY]
      && !wr_mask |=> irq)
      else $error("unmasked parity error gave no interrupt");
   AST_IGNORE: assert property ( // see [R5]
      ign_err && !sts_q[wfp_pkg::EVT_PARITY] |=>
      !sts_q[wfp_pkg::EVT_PARITY])
      else $error("ignored parity error still flagged");
   AST_FIELD_SIGN: assert property ( // see [R8]
      field_sign == word_q[field_pos].zone[1])
      else $error("fixed field sign from wrong character");
   AST_PARTIAL: assert property ( // see [R7]
      xfer_valid && float_op && field_len != wfp_pkg::FULL_LEN
      |=> sts_q[wfp_pkg::EVT_PARTIAL])
      else $error("partial float operand not flagged");
   AST_NEG_ZERO: assert property ( // see [R14]
      xfer_valid && float_op && xfer_in.word[4].zone[1] &&
      xfer_in.word[7].num == 4'h0 && flt_in.is_zero
      |=> sts_q[wfp_pkg::EVT_FORMAT])
      else $error("negative zero fraction not flagged");
   AST_NORM: assert property ( // see [R15]
      $rose(flt_q.normalized) |-> word_q[7].num != 4'h0)
      else $error("normalized flag without top digit");
   AST_WRITE_RESP: assert property (
      wr_go |=> s_axi_bvalid && ($stable(ctrl_q) || $past(wr_ctrl)))
      else $error("write response missing");
   AST_GEN_FIELDS: assert property ( // see [R2]
      gen_valid |=> gen_word[0].zone == $past(gen_code[0].zone) &&
                    gen_word[7].num == $past(gen_code[7].num))
      else $error("generated character lost its code bits");
   AST_ODD_GEN_MID: assert property ( // see [R3]
      gen_done |-> ^gen_word[1] && ^gen_word[2] && ^gen_word[4] &&
                   ^gen_word[5] && ^gen_word[6])
      else $error("generated middle character has even parity");
   AST_NO_GEN: assert property (
      !gen_valid |=> !gen_done)
      else $error("done without a request");
   AST_ERR_INFO: assert property ( // see [R4]
      xfer_valid && |bad_chars |=> err_chars_q == $past(bad_chars) &&
                                   err_src_q == $past(xfer_in.src))
      else $error("error details not captured");
   AST_XFER_QUIET: assert property ( // see [R4]
      !xfer_valid |=> !xfer_err)
      else $error("transfer error without a transfer");
   AST_STICKY: assert property ( // see [R6]
      sts_q[wfp_pkg::EVT_PARITY] && !wr_sts |=> sts_q[wfp_pkg::EVT_PARITY])
      else $error("parity flag dropped without a clear");
   AST_FLOAT_OFF: assert property ( // see [R10]
      !float_op && !sts_q[wfp_pkg::EVT_PARTIAL] |=>
      !sts_q[wfp_pkg::EVT_PARTIAL])
      else $error("partial field flagged outside float mode");
   AST_SIGNS: assert property ( // see [R11]
      flt_q.frac_sign == word_q[4].zone[1] &&
      flt_q.exp_sign == word_q[4].zone[0])
      else $error("float signs from wrong bits");
   AST_EXP_TENS: assert property ( // see [R12]
      flt_q.exp_tens == {word_q[3].zone, word_q[2].zone})
      else $error("exponent tens digit misplaced");
   AST_EXP_RANGE: assert property ( // see [R13]
      xfer_valid && float_op && xfer_in.word[3].zone[1] &&
      (xfer_in.word[3].zone[0] || xfer_in.word[2].zone[1])
      |=> sts_q[wfp_pkg::EVT_FORMAT])
      else $error("exponent above ninety-nine not flagged");
   AST_NEG_EXP_ZERO: assert property ( // see [R14]
      xfer_valid && float_op && xfer_in.word[4].zone[0] &&
      {xfer_in.word[3].zone, xfer_in.word[2].zone, xfer_in.word[1].zone,
       xfer_in.word[0].zone} == 8'h00 |=> sts_q[wfp_pkg::EVT_FORMAT])
      else $error("negative zero exponent not flagged");
   AST_FRAC_TOP: assert property ( // see [R16]
      word_q[7].num != 4'h0 |-> !flt_q.is_zero && flt_q.normalized)
      else $error("top fraction digit not seen");
   AST_WORD_HOLD: assert property ( // see [R17]
      !xfer_valid |=> $stable(word_q))
      else $error("captured word changed without a transfer");
   AST_READ_RESP: assert property (
      rd_go |=> s_axi_rvalid)
      else $error("read response missing");

   COV_PAR_ERR: cover property (par_evt ##1 irq);
   COV_GEN: cover property (gen_valid ##1 gen_done);
   COV_FLOAT_OK: cover property (xfer_valid && float_op && !fmt_evt &&
      flt_in.normalized);
   COV_CLR_SET: cover property (wr_sts && |evt);
endmodule // wfp_unit

// ===== core/wfp_pkg.sv
package wfp_pkg;
   localparam int unsigned NUM_CHARS = 8;
   localparam int unsigned CHAR_BITS = 7;
   localparam int unsigned WORD_BITS = NUM_CHARS * CHAR_BITS;
   localparam int unsigned CODE_BITS = 6;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_ERRINFO = 8'h0C;
   localparam logic [7:0] OFS_WORD_LO = 8'h10;
   localparam logic [7:0] OFS_WORD_HI = 8'h14;
   localparam logic [7:0] OFS_DECODE = 8'h18;

   // control fields
   localparam int unsigned CTRL_IGNORE = 0;
   localparam int unsigned CTRL_FLOAT = 1;
   localparam int unsigned CTRL_POS_LSB = 4;
   localparam int unsigned CTRL_LEN_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0800;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_0F73;

   // status and mask fields
   localparam int unsigned EVT_PARITY = 0;
   localparam int unsigned EVT_PARTIAL = 1;
   localparam int unsigned EVT_FORMAT = 2;
   localparam int unsigned EVT_NUM = 3;

   localparam logic [3:0] FULL_LEN = 4'h8;
   localparam logic [3:0] MAX_DIGIT = 4'h9;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SRC_CORE, SRC_ARITH, SRC_DISC, SRC_UNITREC, SRC_IO
   } wfp_src_t;

   // one character: check bit 7, zone bits 6..5, numeric bits 4..1
   typedef struct packed {
      logic check;
      logic [1:0] zone;
      logic [3:0] num;
   } wfp_char_t;

   typedef wfp_char_t [NUM_CHARS-1:0] wfp_word_t;

   typedef struct packed {
      wfp_src_t src;
      wfp_word_t word;
   } wfp_xfer_t;

   typedef struct packed {
      logic frac_sign;
      logic exp_sign;
      logic [3:0] exp_tens;
      logic [3:0] exp_units;
      logic normalized;
      logic is_zero;
      logic neg_zero;
      logic bad_digit;
   } wfp_float_t;
endpackage

// ===== core/wfp_char_parity.sv
`timescale 1ns/100ps
// per-character odd parity check and check-bit generation
module wfp_char_parity (
   input wire wfp_pkg::wfp_word_t chk_word,
   input wire wfp_pkg::wfp_word_t gen_code,
   output logic [wfp_pkg::NUM_CHARS-1:0] bad,
   output wfp_pkg::wfp_word_t gen_word
);
   genvar i;
   generate
      for (i = 0; i < wfp_pkg::NUM_CHARS; i++) begin : g_char
         // even count of ones over all seven bits is an error
         assign bad[i] = ~^chk_word[i];
         assign gen_word[i].check = ~^{gen_code[i].zone, gen_code[i].num};
         assign gen_word[i].zone = gen_code[i].zone;
         assign gen_word[i].num = gen_code[i].num;
      end
   endgenerate
endmodule // wfp_char_parity

// ===== core/wfp_float_decode.sv
`timescale 1ns/100ps
// floating point layout decode of a full word
module wfp_float_decode (
   input wire wfp_pkg::wfp_word_t word,
   output wfp_pkg::wfp_float_t flt
);
   logic [wfp_pkg::NUM_CHARS-1:0] digit_bad;
   logic [wfp_pkg::NUM_CHARS-1:0] digit_zero;
   logic exp_zero;
   genvar i;
   generate
      for (i = 0; i < wfp_pkg::NUM_CHARS; i++) begin : g_dig
         assign digit_bad[i] = word[i].num > wfp_pkg::MAX_DIGIT;
         assign digit_zero[i] = word[i].num == 4'h0;
      end
   endgenerate
   assign flt.frac_sign = word[4].zone[1];
   assign flt.exp_sign = word[4].zone[0];
   assign flt.exp_tens = {word[3].zone, word[2].zone};
   assign flt.exp_units = {word[1].zone, word[0].zone};
   assign exp_zero = flt.exp_tens == 4'h0 && flt.exp_units == 4'h0;
   assign flt.normalized = !digit_zero[wfp_pkg::NUM_CHARS-1];
   assign flt.is_zero = &digit_zero;
   assign flt.neg_zero = (flt.frac_sign && flt.is_zero) ||
                         (flt.exp_sign && exp_zero);
   assign flt.bad_digit = |digit_bad || flt.exp_tens > wfp_pkg::MAX_DIGIT ||
                          flt.exp_units > wfp_pkg::MAX_DIGIT;
endmodule // wfp_float_decode

// ===== bench/wfp_src_model.sv
`timescale 1ns/100ps
// trunkline source: presents whole words with odd check bits, except in characters marked bad
module wfp_src_model (
   input wire logic aclk,
   output logic xfer_valid,
   output wfp_pkg::wfp_xfer_t xfer_in
);
   initial begin
      xfer_valid = 1'b0;
      xfer_in = '0;
   end

   // bad marks characters whose check bit goes out wrong
   task automatic send(input wfp_pkg::wfp_src_t s,
      input wfp_pkg::wfp_word_t w, input logic [7:0] bad);
      for (int i = 0; i < 8; i++) begin
         w[i].check = ~(^{w[i].zone, w[i].num}) ^ bad[i];
      end
      @(posedge aclk);
      xfer_valid <= 1'b1;
      xfer_in <= {s, w};
      @(posedge aclk);
      xfer_valid <= 1'b0;
      // released lines carry no stale word
      xfer_in.word <= ~w;
      #1;
   endtask
endmodule // wfp_src_model

// ===== bench/wfp_unit_tb_top.sv
`timescale 1ns/100ps
module wfp_unit_tb_top;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, xfer_valid, xfer_err;
   logic gen_valid, gen_done, irq;
   wfp_pkg::wfp_xfer_t xfer_in;
   wfp_pkg::wfp_word_t gen_code, gen_word, fw_ex;
   int fails, samples_checked, cycles;

   wfp_unit uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .xfer_valid(xfer_valid),
      .xfer_in(xfer_in), .xfer_err(xfer_err), .gen_valid(gen_valid),
      .gen_code(gen_code), .gen_word(gen_word), .gen_done(gen_done),
      .irq(irq));
   wfp_src_model src (.aclk(aclk), .xfer_valid(xfer_valid),
      .xfer_in(xfer_in));

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         final_report;
      end
   end

   task automatic check(input string n, input logic [63:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
   endtask

   function automatic wfp_pkg::wfp_word_t fw(input logic [31:0] dg,
      input logic [15:0] zn, input logic withchk);
      wfp_pkg::wfp_word_t w;
      for (int i = 0; i < 8; i++) begin
         w[i].num = dg[4*i+:4];
         w[i].zone = zn[2*i+:2];
         w[i].check = withchk & ~(^{zn[2*i+:2], dg[4*i+:4]});
      end
      return w;
   endfunction

   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_awready);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check("bresp", s_axi_bresp, er);
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] ex,
      input logic [1:0] er, input logic [31:0] m = 32'hFFFF_FFFF);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      check("rdata", s_axi_rdata & m, ex);
      check("rresp", s_axi_rresp, er);
   endtask

   task automatic xf(input wfp_pkg::wfp_src_t s, input wfp_pkg::wfp_word_t w,
      input logic [7:0] bad, input logic irq_e);
      src.send(s, w, bad);
      check("xfer_err", xfer_err, |bad);
      check("irq", irq, irq_e);
   endtask

   task automatic t_regs;
      axr(wfp_pkg::OFS_CTRL, 32'h0000_0800, wfp_pkg::RESP_OKAY);
      axr(wfp_pkg::OFS_STATUS, 32'h0, wfp_pkg::RESP_OKAY);
      axr(wfp_pkg::OFS_MASK, 32'h0, wfp_pkg::RESP_OKAY);
      axr(8'h1C, 32'h0, wfp_pkg::RESP_SLVERR);
      axw(8'h1C, 32'hFFFF_FFFF, wfp_pkg::RESP_SLVERR);
      axw(wfp_pkg::OFS_ERRINFO, 32'hFFFF_FFFF, wfp_pkg::RESP_SLVERR);
      axw(wfp_pkg::OFS_MASK, 32'h0000_0007, wfp_pkg::RESP_OKAY);
      axr(wfp_pkg::OFS_MASK, 32'h0000_0007, wfp_pkg::RESP_OKAY);
   endtask

   // every character position and every source, raised then cleared
   task automatic t_parity;
      wfp_pkg::wfp_src_t s;
      for (int k = 0; k < 8; k++) begin
         s = wfp_pkg::wfp_src_t'(k % 5);
         xf(s, fw_ex, 8'(1 << k), 1'b1);
         axr(wfp_pkg::OFS_ERRINFO, {21'h0, s, 8'(1 << k)},
            wfp_pkg::RESP_OKAY);
         axw(wfp_pkg::OFS_STATUS, 32'h0000_0001, wfp_pkg::RESP_OKAY);
         check("irq_clr", irq, 1'b0);
      end
      xf(wfp_pkg::SRC_CORE, fw_ex, 8'h00, 1'b0);
      xf(wfp_pkg::SRC_IO, fw_ex, 8'h81, 1'b1);
      axr(wfp_pkg::OFS_ERRINFO, 32'h0000_0481, wfp_pkg::RESP_OKAY);
      axw(wfp_pkg::OFS_STATUS, 32'h0000_0001, wfp_pkg::RESP_OKAY);
      axw(wfp_pkg::OFS_CTRL, 32'h0000_0801, wfp_pkg::RESP_OKAY);
      xf(wfp_pkg::SRC_DISC, fw_ex, 8'h04, 1'b0);
      axr(wfp_pkg::OFS_STATUS, 32'h0, wfp_pkg::RESP_OKAY);
      axw(wfp_pkg::OFS_CTRL, 32'h0000_0800, wfp_pkg::RESP_OKAY);
      axw(wfp_pkg::OFS_MASK, 32'h0000_0006, wfp_pkg::RESP_OKAY);
      xf(wfp_pkg::SRC_ARITH, fw_ex, 8'h10, 1'b0);
      axr(wfp_pkg::OFS_STATUS, 32'h0000_0001, wfp_pkg::RESP_OKAY);
      axw(wfp_pkg::OFS_STATUS, 32'h0000_0001, wfp_pkg::RESP_OKAY);
   endtask

   task automatic t_float;
      wfp_pkg::wfp_word_t w;
      logic [55:0] wb;
      w = fw(32'h1620_0000, 16'h0115, 1'b1);
      wb = w;
      axw(wfp_pkg::OFS_CTRL, 32'h0000_0802, wfp_pkg::RESP_OKAY);
      xf(wfp_pkg::SRC_ARITH, w, 8'h00, 1'b0);
      axr(wfp_pkg::OFS_WORD_LO, wb[31:0], wfp_pkg::RESP_OKAY);
      axr(wfp_pkg::OFS_WORD_HI, {8'h0, wb[55:32]},
         wfp_pkg::RESP_OKAY);
      axr(wfp_pkg::OFS_DECODE, 32'h0000_1518, wfp_pkg::RESP_OKAY,
         32'h0000_FFFC);
      axr(wfp_pkg::OFS_STATUS, 32'h0, wfp_pkg::RESP_OKAY);
      xf(wfp_pkg::SRC_CORE, fw(32'h0, 16'h0200, 1'b0), 8'h00,
         1'b1);
      axr(wfp_pkg::OFS_DECODE, 32'h0000_6000, wfp_pkg::RESP_OKAY,
         32'h0000_7000);
      axw(wfp_pkg::OFS_STATUS, 32'h0000_0004, wfp_pkg::RESP_OKAY);
      xf(wfp_pkg::SRC_CORE, fw(32'h0, 16'h0100, 1'b0), 8'h00,
         1'b1);
      axr(wfp_pkg::OFS_DECODE, 32'h0000_4000, wfp_pkg::RESP_OKAY,
         32'h0000_4000);
      axw(wfp_pkg::OFS_STATUS, 32'h0000_0004, wfp_pkg::RESP_OKAY);
      xf(wfp_pkg::SRC_CORE, fw(32'h1000_0000, 16'h00A0, 1'b0), 8'h00,
         1'b1);
      axr(wfp_pkg::OFS_DECODE, 32'h0000_8000, wfp_pkg::RESP_OKAY,
         32'h0000_8000);
      axw(wfp_pkg::OFS_STATUS, 32'h0000_0004, wfp_pkg::RESP_OKAY);
      axw(wfp_pkg::OFS_CTRL, 32'h0000_0402, wfp_pkg::RESP_OKAY);
      xf(wfp_pkg::SRC_CORE, fw_ex, 8'h00, 1'b1);
      axr(wfp_pkg::OFS_STATUS, 32'h0000_0002, wfp_pkg::RESP_OKAY);
      axw(wfp_pkg::OFS_STATUS, 32'h0000_0007, wfp_pkg::RESP_OKAY);
   endtask

   // field of three characters at position two
   task automatic t_fixed;
      axw(wfp_pkg::OFS_CTRL, 32'h0000_0320, wfp_pkg::RESP_OKAY);
      xf(wfp_pkg::SRC_CORE, fw(32'h125, 16'h0020, 1'b0), 8'h00,
         1'b0);
      axr(wfp_pkg::OFS_DECODE, 32'h1, wfp_pkg::RESP_OKAY, 32'h3);
      xf(wfp_pkg::SRC_CORE, fw(32'h125, 16'h0040, 1'b0), 8'h00, 1'b0);
      axr(wfp_pkg::OFS_DECODE, 32'h2, wfp_pkg::RESP_OKAY, 32'h3);
   endtask

   task automatic t_gen;
      logic [55:0] codes [3];
      wfp_pkg::wfp_word_t e;
      codes = '{56'h00_0000_0000_0000, 56'hFF_FFFF_FFFF_FFFF,
         56'h12_3456_789A_BCDE};
      foreach (codes[j]) begin
         e = codes[j];
         // check bit makes the count of ones odd
         for (int i = 0; i < 8; i++) begin
            e[i].check = $countones({e[i].zone, e[i].num}) % 2 == 0;
         end
         @(posedge aclk);
         gen_valid <= 1'b1;
         gen_code <= codes[j];
         @(posedge aclk);
         gen_valid <= 1'b0;
         #1;
         check("gen_done", gen_done, 1'b1);
         check("gen_word", gen_word, e);
      end
   endtask

   initial begin
      fails = 0;
      samples_checked = 0;
      cycles = 0;
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      gen_valid = 1'b0;
      gen_code = '0;
      fw_ex = fw(32'h0000_0125, 16'h0, 1'b0);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_parity();
      t_float();
      t_fixed();
      t_gen();
      final_report;
   end
endmodule // wfp_unit_tb_top
